// File: two_wire_defines.vh
/*
 constants for the two-wire eeprom slave bus block: timing figures and cycle counts.
 assumes a 50 MHz ref_clk; included by its bare name.
*/
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS          20
`define CLK_FREQ_KHZ           50000

// ----------------------------------------------------------------------
// timing figures and derived counts
// ----------------------------------------------------------------------
// glitch reject width: longest spike rejected, rounded up to whole cycles plus one
`define GLITCH_REJECT_WIDTH_NS 50
`define GLITCH_CYCLES          ((`GLITCH_REJECT_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
// least hold of sda after scl falls, rounded up
`define CLOCK_TO_OUTPUT_DELAY_NS 300
`define HOLD_CYCLES            ((`CLOCK_TO_OUTPUT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// programming time per page, longest bound, a whole number of cycles with no rounding
`define WRITE_PAGE_MS          5
`define WRITE_PAGE_CYCLES      (`WRITE_PAGE_MS * `CLK_FREQ_KHZ)
`define PAGE_BYTES             8
`define PAGE_COUNT_MAX         8

`endif

// File: spike_filter.v
/*
 spike filter: synchronises one bus line and passes a new level only after it has
 stood for a number of cycles. assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module spike_filter
#(
    parameter STABLE_CYCLES = 4,
    parameter CW            = 4
)
(
    // clock and reset
    input  wire clk,
    input  wire rst,
    // line
    input  wire line_in,
    output reg  line_q
);
    reg          sync1_q;
    reg          sync2_q;
    reg [CW-1:0] cnt_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            cnt_q   <= {CW{1'b0}};
            line_q  <= 1'b1;
        end
        else
        begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            // a differing level must persist before it is accepted
            if (sync2_q == line_q)
                cnt_q <= {CW{1'b0}};
            else if (cnt_q == STABLE_CYCLES[CW-1:0] - 1'b1)
            begin
                cnt_q  <= {CW{1'b0}};
                line_q <= sync2_q;
            end
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // spike_filter

// File: eeprom_two_wire_slave_bus.v
/*
 bus-level slave of a serial eeprom on a two-wire bus: spike filtering, start and stop
 detection, bit and byte framing, acknowledge, transmit with output hold, and the
 self-timed programming cycle. byte meaning is decided by the user side.
 assumes an external master makes scl and all start/stop; sda is open drain.
*/
// Overview of operation
// - the master chooses the direction, the user side tells whether the block transmits.
// - sda is kept stable while scl is high and any change then is taken as start or stop.
// - driven sda is held for at least 300 ns after each scl falling edge.
// - spikes up to 50 ns on sda and scl are rejected before any edge is seen.
// - the programming cycle lasts at most 5 ms per cached page of 8 bytes.
// - sda falling with scl high is start, sda rising with scl high is stop.
// - after a received byte the block pulls sda low for the ninth clock pulse, only while rx_ack_en is set and prog_busy is low.
// - when the master does not acknowledge a read byte the block releases sda.
`timescale 1ns/1ns
`include "two_wire_defines.vh"
module eeprom_two_wire_slave_bus
#(
    parameter WRITE_PAGE_CYCLES = `WRITE_PAGE_CYCLES
)
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       sys_rst,
    // bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // receive side
    output reg  [7:0] rx_byte,
    output reg        rx_valid,
    input  wire       rx_ack_en,
    // transmit side
    input  wire       tx_mode,
    input  wire [7:0] tx_byte,
    output reg        tx_taken,
    output reg        tx_nack,
    // framing
    output reg        start_seen,
    output reg        stop_seen,
    output reg        bus_busy,
    // programming cycle
    input  wire       prog_start,
    input  wire [3:0] prog_pages,
    output reg        prog_busy
);
    // ------------------------------------------------------------------
    // filtered lines
    // ------------------------------------------------------------------
    wire scl_f;
    wire sda_f;

    spike_filter #(.STABLE_CYCLES(`GLITCH_CYCLES), .CW(4)) u_scl_filter
    (
        .clk     (ref_clk),
        .rst     (sys_rst),
        .line_in (scl_in),
        .line_q  (scl_f)
    );

    spike_filter #(.STABLE_CYCLES(`GLITCH_CYCLES), .CW(4)) u_sda_filter
    (
        .clk     (ref_clk),
        .rst     (sys_rst),
        .line_in (sda_in),
        .line_q  (sda_f)
    );

    reg scl_d1_q;
    reg sda_d1_q;
    wire scl_rise = scl_f & ~scl_d1_q;
    wire scl_fall = ~scl_f & scl_d1_q;
    wire start_ev = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
    wire stop_ev  = scl_f & scl_d1_q & ~sda_d1_q & sda_f;

    // ------------------------------------------------------------------
    // bit framing
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_ACK  = 2'd2;
    // hold count kept as a ranged constant so its low bits can be taken on purpose
    localparam [31:0] HOLD_W = `HOLD_CYCLES;

    reg [1:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg       dir_tx_q;
    reg       drive_d;
    reg       drive_q;
    reg       pend_q;
    reg       pend_val_q;
    reg [4:0] hold_q;
    reg [31:0] prog_cnt_q;

    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scl_d1_q   <= 1'b1;
            sda_d1_q   <= 1'b1;
            state_q    <= ST_IDLE;
            bit_q      <= 4'h0;
            shift_q    <= 8'h00;
            dir_tx_q   <= 1'b0;
            rx_byte    <= 8'h00;
            rx_valid   <= 1'b0;
            tx_taken   <= 1'b0;
            tx_nack    <= 1'b0;
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
            bus_busy   <= 1'b0;
            pend_q     <= 1'b0;
            pend_val_q <= 1'b1;
        end
        else
        begin
            scl_d1_q   <= scl_f;
            sda_d1_q   <= sda_f;
            rx_valid   <= 1'b0;
            tx_taken   <= 1'b0;
            start_seen <= start_ev;
            stop_seen  <= stop_ev;
            if (start_ev)
            begin
                // repeated start also restarts framing
                state_q  <= ST_DATA;
                bit_q    <= 4'h0;
                dir_tx_q <= 1'b0;
                bus_busy <= 1'b1;
                tx_nack  <= 1'b0;
                pend_q   <= 1'b1;
                pend_val_q <= 1'b1;
            end
            else if (stop_ev)
            begin
                state_q  <= ST_IDLE;
                bus_busy <= 1'b0;
                tx_nack  <= 1'b0;
                pend_q   <= 1'b1;
                pend_val_q <= 1'b1;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                        state_q <= ST_IDLE;
                    ST_DATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= {shift_q[6:0], sda_f};
                            bit_q   <= bit_q + 4'h1;
                        end
                        if (scl_fall)
                        begin
                            if (bit_q == 4'h8)
                            begin
                                state_q <= ST_ACK;
                                if (!dir_tx_q)
                                begin
                                    rx_byte  <= shift_q;
                                    rx_valid <= 1'b1;
                                end
                                // acknowledge only when allowed and idle inside
                                pend_val_q <= dir_tx_q | ~(rx_ack_en & ~prog_busy);
                            end
                            else
                                // the next bit to send has been shifted up to the top
                                pend_val_q <= ~dir_tx_q | shift_q[7];
                            pend_q <= 1'b1;
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_rise && dir_tx_q)
                            tx_nack <= sda_f;
                        if (scl_fall)
                        begin
                            bit_q <= 4'h0;
                            state_q <= ST_DATA;
                            // nack level is held through the ack bit, used here, then dropped
                            tx_nack <= 1'b0;
                            pend_q <= 1'b1;
                            // direction follows what the user side says
                            if (tx_mode && !(dir_tx_q && tx_nack))
                            begin
                                dir_tx_q   <= 1'b1;
                                shift_q    <= tx_byte;
                                tx_taken   <= 1'b1;
                                pend_val_q <= tx_byte[7];
                            end
                            else
                            begin
                                // a refused read byte leaves sda high
                                if (dir_tx_q && tx_nack)
                                    state_q <= ST_IDLE;
                                dir_tx_q   <= 1'b0;
                                pend_val_q <= 1'b1;
                            end
                        end
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
                if (pend_q && hold_q == 5'd0 && !scl_fall)
                    pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // output with hold after scl falling edge
    // ------------------------------------------------------------------
    always @*
    begin
        drive_d = drive_q;
        if (pend_q && hold_q == 5'd0)
            drive_d = ~pend_val_q;
        if (start_ev || stop_ev)
            drive_d = 1'b0;
    end

    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hold_q  <= 5'd0;
            drive_q <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end
        else
        begin
            if (scl_fall)
                hold_q <= HOLD_W[4:0];
            else if (hold_q != 5'd0)
                hold_q <= hold_q - 5'd1;
            drive_q <= drive_d;
            sda_out <= 1'b0;
            sda_oe  <= drive_d;
        end
    end

    // ------------------------------------------------------------------
    // self-timed programming cycle
    // ------------------------------------------------------------------
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prog_cnt_q <= 32'h0000_0000;
            prog_busy  <= 1'b0;
        end
        else if (prog_busy)
        begin
            if (prog_cnt_q <= 32'h0000_0001)
                prog_busy <= 1'b0;
            prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
        end
        else if (prog_start && prog_pages != 4'h0)
        begin
            // bound scales with pages, capped at the cache size
            prog_cnt_q <= WRITE_PAGE_CYCLES *
                ((prog_pages > `PAGE_COUNT_MAX) ? `PAGE_COUNT_MAX : prog_pages);
            prog_busy  <= 1'b1;
        end
    end
endmodule // eeprom_two_wire_slave_bus

// File: two_wire_master.sv
/*
 two-wire bus master model: makes scl, start, stop and bits.
 assumes sda is wired-and with a pull-up in the bench.
*/
`timescale 1ns/1ns
module two_wire_master
(
    // bus
    output reg  scl,
    output reg  sda_low,
    input  wire sda
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // low phase is 640 ns so the slave's 300 ns hold ends well before scl rises
    task automatic bit_x(input b, output r);
        #320 sda_low = !b;
        #320 scl = 1'b1;
        #160 r = sda;
        #160 scl = 1'b0;
    endtask
    task automatic start_c;
        if (!scl)
        begin
            #320 sda_low = 1'b0;
            #320 scl = 1'b1;
        end
        #320 sda_low = 1'b1;
        #320 scl = 1'b0;
    endtask
    task automatic stop_c;
        #320 sda_low = 1'b1;
        #320 scl = 1'b1;
        #320 sda_low = 1'b0;
        #320;
    endtask
    // reading is sending 8'hff; ack_in high ends a read
    task automatic byte_x(input [7:0] d, input ack_in, output [7:0] q, output ack);
        integer k;
        for (k = 7; k >= 0; k--)
            bit_x(d[k], q[k]);
        bit_x(ack_in, ack);
    endtask
endmodule // two_wire_master

// File: two_wire_slave_props.sv
/*
 assertions on the ports of the two-wire eeprom slave bus block.
 assumes one domain, ref_clk, with sys_rst asynchronous and active high.
*/
`timescale 1ns/1ns
module two_wire_slave_props
#(
    parameter WRITE_PAGE_CYCLES = 50
)
(
    input wire ref_clk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_oe,
    input wire rx_valid,
    input wire rx_ack_en,
    input wire tx_nack,
    input wire start_seen,
    input wire stop_seen,
    input wire bus_busy,
    input wire prog_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    reg [31:0] busy_len_q;
    always @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
            busy_len_q <= 32'h0000_0000;
        else
            busy_len_q <= prog_busy ? busy_len_q + 32'h0000_0001 : 32'h0000_0000;
    a_idle_release: assert property (!bus_busy && !$past(bus_busy) |-> !sda_oe)
        else $error("sda driven outside a transaction");
    a_hold_after_fall: assert property ($fell(scl_in) |=> $stable(sda_oe) [*8])
        else $error("sda drive changed too soon after scl fell");
    a_change_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda drive changed while scl high");
    a_start_busy: assert property (start_seen |-> ##[0:1] bus_busy)
        else $error("start did not mark the bus busy");
    a_stop_idle: assert property (stop_seen |-> ##[0:1] !bus_busy)
        else $error("stop did not free the bus");
    a_ack_drive: assert property (rx_valid && rx_ack_en && !prog_busy |-> ##[1:24] sda_oe)
        else $error("received byte not acknowledged");
    a_no_ack_busy: assert property (rx_valid && prog_busy |->
        ##1 (!sda_oe) [*8] ##1 (!sda_oe) [*8] ##1 (!sda_oe) [*8])
        else $error("byte acknowledged while programming");
    a_nack_release: assert property (tx_nack |-> !sda_oe)
        else $error("sda held after master refused a byte");
    a_prog_bound: assert property (busy_len_q <= WRITE_PAGE_CYCLES * 8)
        else $error("programming cycle too long");
endmodule // two_wire_slave_props
bind eeprom_two_wire_slave_bus two_wire_slave_props #(.WRITE_PAGE_CYCLES(WRITE_PAGE_CYCLES))
    props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_oe(sda_oe),
    .rx_valid(rx_valid), .rx_ack_en(rx_ack_en), .tx_nack(tx_nack), .start_seen(start_seen),
    .stop_seen(stop_seen), .bus_busy(bus_busy), .prog_busy(prog_busy));

// File: test_eeprom_two_wire_slave_bus.sv
/*
 self-checking bench for the two-wire eeprom slave bus block.
 assumes the master model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
module test_eeprom_two_wire_slave_bus;
    reg        ref_clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        rx_ack_en = 1'b0;
    reg        tx_mode = 1'b0;
    reg  [7:0] tx_byte = 8'h00;
    reg        prog_start = 1'b0;
    reg  [3:0] prog_pages = 4'h0;
    reg        glitch_sda = 1'b0;
    reg        glitch_scl = 1'b0;
    wire       scl, m_low, sda_oe, rx_valid, tx_nack, start_seen, bus_busy, prog_busy;
    wire       sda_out, tx_taken, stop_seen;
    integer    n_stop = 0;
    integer    n_taken = 0;
    wire [7:0] rx_byte;
    wire       sda_w = !(m_low | sda_oe);
    integer    n_fail = 0;
    integer    comparisons = 0;
    integer    n_start = 0;
    integer    busy_cnt = 0;
    integer    i, p;
    reg        saw_nack = 1'b0;
    reg        a;
    reg  [7:0] d, r;
    reg  [7:0] exp_q[$];
    always #10 ref_clk = ~ref_clk;
    two_wire_master two_wire_master_inst (.scl(scl), .sda_low(m_low), .sda(sda_w));
    // short programming page so the run stays brief
    eeprom_two_wire_slave_bus #(.WRITE_PAGE_CYCLES(200)) eeprom_two_wire_slave_bus_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl & !glitch_scl),
        .sda_in(sda_w & !glitch_sda), .sda_out(sda_out), .sda_oe(sda_oe), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_ack_en(rx_ack_en), .tx_mode(tx_mode), .tx_byte(tx_byte),
        .tx_taken(tx_taken), .tx_nack(tx_nack), .start_seen(start_seen),
        .stop_seen(stop_seen),
        .bus_busy(bus_busy), .prog_start(prog_start), .prog_pages(prog_pages),
        .prog_busy(prog_busy));
    task check(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watcher: each received byte takes the oldest expectation
    always @(posedge ref_clk)
    begin
        if (rx_valid && exp_q.size() == 0)
            check(0, 1);
        else if (rx_valid)
            check(rx_byte, exp_q.pop_front());
        if (start_seen)
            n_start = n_start + 1;
        if (stop_seen)
            n_stop = n_stop + 1;
        if (tx_taken)
            n_taken = n_taken + 1;
        // open drain: the level driven is always low, only the enable moves
        if (sda_out !== 1'b0)
            check(sda_out, 0);
        if (tx_nack)
            saw_nack = 1'b1;
        busy_cnt = prog_start ? 0 : busy_cnt + prog_busy;
    end
    initial
    begin
        void'($urandom(32'hb7de_0c86));
        repeat (7) @(negedge ref_clk);
        sys_rst = 1'b0;
        #3 glitch_sda = 1'b1;
        #40 glitch_sda = 1'b0;
        #300 glitch_scl = 1'b1;
        #40 glitch_scl = 1'b0;
        #300 check(n_start, 0);
        check(bus_busy, 0);
        two_wire_master_inst.start_c;
        check(bus_busy, 1);
        for (i = 0; i < 3; i++)
        begin
            @(negedge ref_clk) rx_ack_en = (i < 2);
            d = $urandom;
            exp_q.push_back(d);
            two_wire_master_inst.byte_x(d, 1'b1, r, a);
            check(a, i == 2);
        end
        two_wire_master_inst.stop_c;
        #200 check(bus_busy, 0);
        check(n_stop, 1);
        @(negedge ref_clk) rx_ack_en = 1'b1;
        tx_mode = 1'b1;
        tx_byte = $urandom;
        d = $urandom;
        exp_q.push_back(d);
        two_wire_master_inst.start_c;
        two_wire_master_inst.byte_x(d, 1'b1, r, a);
        check(a, 0);
        two_wire_master_inst.byte_x(8'hff, 1'b1, r, a);
        check(r, tx_byte);
        check(a, 1);
        check(saw_nack, 1);
        check(n_taken, 1);
        two_wire_master_inst.stop_c;
        @(negedge ref_clk) tx_mode = 1'b0;
        // 15 pages lies past the cache size and must be capped at 8
        for (p = 1; p <= 15; p += 7)
        begin
            @(negedge ref_clk) prog_pages = p[3:0];
            prog_start = 1'b1;
            @(negedge ref_clk) prog_start = 1'b0;
            if (p == 8)
            begin
                d = $urandom;
                exp_q.push_back(d);
                two_wire_master_inst.start_c;
                two_wire_master_inst.byte_x(d, 1'b1, r, a);
                check(a, 1);
                two_wire_master_inst.stop_c;
            end
            for (i = 0; i < 2000 && prog_busy; i++)
                @(negedge ref_clk);
            check(busy_cnt > 0 && busy_cnt <= ((p > 8) ? 8 : p) * 200, 1);
            check(prog_busy, 0);
        end
        @(negedge ref_clk) prog_pages = 4'h0;
        prog_start = 1'b1;
        @(negedge ref_clk) prog_start = 1'b0;
        @(negedge ref_clk) check(prog_busy, 0);
        check(exp_q.size(), 0);
        finish_test;
    end
endmodule // test_eeprom_two_wire_slave_bus
